//--- src/ghmt_tracker.v
// holdover mode tracker: mode sequencer, holdover cause, duration, grades
// assumes gps engine and loop inputs on core_clk; pps edges asynchronous
`timescale 1ns/1ps
`include "ghmt_consts.vh"

module ghmt_tracker (
  // clock and reset
  input  wire                       core_clk,
  input  wire                       reset,
  // gps engine status
  input  wire                       ref_pps_valid,
  input  wire                       sats_tracked,
  input  wire                       ref_pps_in,
  // oscillator loop
  input  wire                       own_pps_in,
  input  wire                       loop_locked,
  input  wire                       loop_stable,
  input  wire                       osc_freq_ok,
  input  wire                       meas_hw_error,
  input  wire [3:0]                 time_error_decade,
  // host commands and configuration
  input  wire                       hold_request,
  input  wire                       hold_exit,
  input  wire [`GHMT_PHASE_W-1:0]   holdover_limit,
  // status
  output reg  [`GHMT_MODE_W-1:0]    mode,
  output reg  [`GHMT_CAUSE_W-1:0]   hold_cause,
  output reg  [`GHMT_SUM_W-1:0]     output_summary,
  output reg  [`GHMT_GRADE_W-1:0]   time_accuracy_grade,
  output reg  [1:0]                 frequency_stability_grade,
  output reg  [`GHMT_DUR_W-1:0]     hold_seconds,
  output reg  [`GHMT_PHASE_W-1:0]   pulse_phase_offset,
  output reg                        offset_negative,
  output reg                        lock_led,
  output reg                        pps_usable,
  output reg                        freq_settling,
  output reg                        osc_steer_en
);

  localparam [3:0] ST_PWRUP  = `GHMT_MODE_PWRUP;
  localparam [3:0] ST_LOCKED = `GHMT_MODE_LOCKED;
  localparam [3:0] ST_RECOV  = `GHMT_MODE_RECOV;
  localparam [3:0] ST_HOLD   = `GHMT_MODE_HOLD;
  localparam [`GHMT_SECCNT_W-1:0] SEC_LAST =
    `GHMT_SEC_LAST;

  // three-stage synchronisers for the two pulse inputs
  reg  [2:0] ref_sync_q;
  reg  [2:0] own_sync_q;
  reg        ref_lvl_q;
  reg        own_lvl_q;
  wire       ref_lvl_d = (ref_sync_q[1] == ref_sync_q[2]) ?
                         ref_sync_q[2] : ref_lvl_q;
  wire       own_lvl_d = (own_sync_q[1] == own_sync_q[2]) ?
                         own_sync_q[2] : own_lvl_q;
  wire       ref_rise  = ref_lvl_d & ~ref_lvl_q;
  wire       own_rise  = own_lvl_d & ~own_lvl_q;

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      ref_sync_q <= 3'h0;
      own_sync_q <= 3'h0;
      ref_lvl_q  <= 1'b0;
      own_lvl_q  <= 1'b0;
    end
    else
    begin
      ref_sync_q <= {ref_sync_q[1:0], ref_pps_in};
      own_sync_q <= {own_sync_q[1:0], own_pps_in};
      ref_lvl_q  <= ref_lvl_d;
      own_lvl_q  <= own_lvl_d;
    end
  end

  // phase measurement: count cycles between the two pulse edges
  reg                      meas_run_q;
  reg                      meas_ref_first_q;
  reg [`GHMT_PHASE_W-1:0]  meas_cnt_q;
  // an edge with no partner inside one second gives up on the pair
  wire [`GHMT_PHASE_W-1:0] meas_last =
    {{(`GHMT_PHASE_W-`GHMT_SECCNT_W){1'b0}}, SEC_LAST};

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      meas_run_q         <= 1'b0;
      meas_ref_first_q   <= 1'b0;
      meas_cnt_q         <= {`GHMT_PHASE_W{1'b0}};
      pulse_phase_offset <= {`GHMT_PHASE_W{1'b0}};
      offset_negative    <= 1'b0;
    end
    else if (ref_rise && own_rise)
    begin
      meas_run_q         <= 1'b0;
      pulse_phase_offset <= {`GHMT_PHASE_W{1'b0}};
      offset_negative    <= 1'b0;
    end
    else if (!meas_run_q && (ref_rise || own_rise))
    begin
      meas_run_q       <= 1'b1;
      meas_ref_first_q <= ref_rise;
      meas_cnt_q       <= {{(`GHMT_PHASE_W-1){1'b0}}, 1'b1};
    end
    else if (meas_run_q)
    begin
      if ((meas_ref_first_q && own_rise) || (!meas_ref_first_q && ref_rise))
      begin
        meas_run_q         <= 1'b0;
        pulse_phase_offset <= meas_cnt_q;
        offset_negative    <= ~meas_ref_first_q;
      end
      else if (meas_cnt_q != meas_last)
        meas_cnt_q <= meas_cnt_q + 1'b1;
      else
        meas_run_q <= 1'b0;
    end
  end

  // threshold compare on the last measurement
  wire over_limit = (pulse_phase_offset > holdover_limit);

  // mode sequencer; a host request outranks every fault so that a manual
  // holdover is never recorded under another cause
  reg [3:0]               state_q;
  reg [3:0]               state_d;
  reg [`GHMT_CAUSE_W-1:0] cause_d;
  reg [`GHMT_CAUSE_W-1:0] cause_q;

  always @*
  begin
    state_d = state_q;
    cause_d = cause_q;
    case (state_q)
      ST_PWRUP:
      begin
        if (ref_pps_valid && sats_tracked && osc_freq_ok)
          state_d = ST_LOCKED;
      end
      ST_LOCKED:
      begin
        if (hold_request)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_MANUAL;
        end
        else if (meas_hw_error)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_HWFAULT;
        end
        else if (!ref_pps_valid)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_REFINV;
        end
        else if (over_limit)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_THRESH;
        end
      end
      ST_RECOV:
      begin
        if (hold_request)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_MANUAL;
        end
        else if (meas_hw_error)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_HWFAULT;
        end
        else if (!ref_pps_valid || !sats_tracked)
        begin
          state_d = ST_HOLD;
          cause_d = `GHMT_CAUSE_REFINV;
        end
        else if (loop_locked)
        begin
          state_d = ST_LOCKED;
          cause_d = `GHMT_CAUSE_NONE;
        end
      end
      ST_HOLD:
      begin
        if (cause_q == `GHMT_CAUSE_MANUAL)
        begin
          if (hold_exit)
            state_d = ST_RECOV;
        end
        else if (hold_request)
          cause_d = `GHMT_CAUSE_MANUAL;
        else if (ref_pps_valid && sats_tracked && !meas_hw_error)
          state_d = ST_RECOV;
      end
      default:
      begin
        state_d = ST_PWRUP;
        cause_d = `GHMT_CAUSE_NONE;
      end
    endcase
  end

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      state_q <= ST_PWRUP;
      cause_q <= `GHMT_CAUSE_NONE;
    end
    else
    begin
      state_q <= state_d;
      cause_q <= cause_d;
    end
  end

  // holdover duration in seconds, kept through recovery
  reg [`GHMT_SECCNT_W-1:0] sec_div_q;
  wire in_hold_or_recov = (state_q == ST_HOLD) || (state_q == ST_RECOV);
  wire hold_entry = (state_d == ST_HOLD) && !in_hold_or_recov;

  always @(posedge core_clk)
  begin
    if (reset)
    begin
      sec_div_q    <= {`GHMT_SECCNT_W{1'b0}};
      hold_seconds <= {`GHMT_DUR_W{1'b0}};
    end
    else if (hold_entry)
    begin
      sec_div_q    <= {`GHMT_SECCNT_W{1'b0}};
      hold_seconds <= {`GHMT_DUR_W{1'b0}};
    end
    else if (in_hold_or_recov)
    begin
      if (sec_div_q == SEC_LAST)
      begin
        sec_div_q    <= {`GHMT_SECCNT_W{1'b0}};
        hold_seconds <= hold_seconds + 1'b1;
      end
      else
        sec_div_q <= sec_div_q + 1'b1;
    end
  end

  // time grade clamped into the allowed range
  function [`GHMT_GRADE_W-1:0] clamp_grade;
    input [3:0] dec;
    begin
      if (dec < `GHMT_TGRADE_MIN)
        clamp_grade = `GHMT_TGRADE_MIN;
      else if (dec > `GHMT_TGRADE_MAX)
        clamp_grade = `GHMT_TGRADE_MAX;
      else
        clamp_grade = dec;
    end
  endfunction

  // mode, cause and indicator flags follow the state one cycle later
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      mode          <= `GHMT_MODE_PWRUP;
      hold_cause    <= `GHMT_CAUSE_NONE;
      lock_led      <= 1'b0;
      pps_usable    <= 1'b0;
      freq_settling <= 1'b0;
      osc_steer_en  <= 1'b0;
    end
    else
    begin
      mode          <= state_q;
      hold_cause    <= cause_q;
      lock_led      <= (state_q == ST_LOCKED);
      osc_steer_en  <= (state_q == ST_PWRUP);
      pps_usable    <= (state_q == ST_LOCKED);
      freq_settling <= (state_q == ST_LOCKED) && !loop_stable;
    end
  end

  // time grade: no error figure is trusted before the first lock
  always @(posedge core_clk)
  begin
    if (reset)
      time_accuracy_grade <= `GHMT_TGRADE_MAX;
    else if (state_q == ST_PWRUP)
      time_accuracy_grade <= `GHMT_TGRADE_MAX;
    else
      time_accuracy_grade <= clamp_grade(time_error_decade);
  end

  // output summary and frequency grade
  always @(posedge core_clk)
  begin
    if (reset)
    begin
      output_summary            <= `GHMT_SUM_INVALID;
      frequency_stability_grade <= `GHMT_FGRADE_NOUSE;
    end
    else
    begin
      if (state_q == ST_PWRUP)
        output_summary <= `GHMT_SUM_INVALID;
      else if (state_q == ST_LOCKED && loop_stable)
        output_summary <= `GHMT_SUM_VALID;
      else
        output_summary <= `GHMT_SUM_REDUCED;
      if (state_q == ST_LOCKED && loop_stable)
        frequency_stability_grade <= `GHMT_FGRADE_STABLE;
      else if (state_q == ST_LOCKED || state_q == ST_RECOV)
        frequency_stability_grade <= `GHMT_FGRADE_SETTLING;
      else if (state_q == ST_HOLD)
        frequency_stability_grade <= `GHMT_FGRADE_HOLD;
      else
        frequency_stability_grade <= `GHMT_FGRADE_NOUSE;
    end
  end

endmodule

//--- common/ghmt_consts.vh
// constants for the holdover mode tracker
// assumes one 200 MHz core clock; included by the tracker and its bench
`ifndef GHMT_CONSTS_VH
`define GHMT_CONSTS_VH

// clock figures
`define GHMT_CLK_MHZ          200
`define GHMT_SEC_NS           1000000000
`define GHMT_CLK_NS           5
// one second in core cycles
`define GHMT_SEC_CYCLES       (`GHMT_SEC_NS / `GHMT_CLK_NS)
// last divider count of a second, sized for the second counter
`define GHMT_SEC_LAST         28'hbebc1ff

// mode codes, one-hot
`define GHMT_MODE_W           4
`define GHMT_MODE_PWRUP       4'h1
`define GHMT_MODE_LOCKED      4'h2
`define GHMT_MODE_RECOV       4'h4
`define GHMT_MODE_HOLD        4'h8

// holdover cause codes
`define GHMT_CAUSE_W          3
`define GHMT_CAUSE_NONE       3'h0
`define GHMT_CAUSE_REFINV     3'h1
`define GHMT_CAUSE_MANUAL     3'h2
`define GHMT_CAUSE_THRESH     3'h3
`define GHMT_CAUSE_HWFAULT    3'h4

// output summary codes
`define GHMT_SUM_W            2
`define GHMT_SUM_INVALID      2'h0
`define GHMT_SUM_REDUCED      2'h1
`define GHMT_SUM_VALID        2'h2

// grades
`define GHMT_GRADE_W          4
`define GHMT_TGRADE_MIN       4'h3
`define GHMT_TGRADE_MAX       4'h9
`define GHMT_FGRADE_STABLE    2'h0
`define GHMT_FGRADE_SETTLING  2'h1
`define GHMT_FGRADE_HOLD      2'h2
`define GHMT_FGRADE_NOUSE     2'h3

// widths
`define GHMT_PHASE_W          32
`define GHMT_DUR_W            32
`define GHMT_SECCNT_W         28

`endif

//--- bench/ghmt_assertions.sv
// concurrent checks on the tracker status outputs
// assumes a bind onto ghmt_tracker; sees only its ports
`timescale 1ns/1ps
`include "ghmt_consts.vh"
module ghmt_assertions (
  // clock and reset
  input wire       core_clk,
  input wire       reset,
  // status
  input wire [3:0]  mode,
  input wire [2:0]  hold_cause,
  input wire [1:0]  output_summary,
  input wire [3:0]  time_accuracy_grade,
  input wire [1:0]  frequency_stability_grade,
  input wire [31:0] hold_seconds,
  input wire        lock_led,
  input wire        pps_usable,
  input wire        freq_settling,
  input wire        osc_steer_en,
  // host
  input wire        hold_exit
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  property p_onehot;
    $onehot(mode);
  endproperty
  a_onehot: assert property (p_onehot) else $error("mode not one-hot");
  property p_led;
    !$past(reset) |-> lock_led == (mode == `GHMT_MODE_LOCKED);
  endproperty
  a_led: assert property (p_led) else $error("lock led wrong");
  property p_steer;
    !$past(reset) |-> osc_steer_en == (mode == `GHMT_MODE_PWRUP);
  endproperty
  a_steer: assert property (p_steer) else $error("steer wrong");
  property p_pwrup;
    mode == `GHMT_MODE_PWRUP |-> output_summary == `GHMT_SUM_INVALID
      && time_accuracy_grade == 4'h9;
  endproperty
  a_pwrup: assert property (p_pwrup) else $error("power-up status");
  property p_valid;
    output_summary == `GHMT_SUM_VALID |-> mode == `GHMT_MODE_LOCKED
      && frequency_stability_grade == `GHMT_FGRADE_STABLE;
  endproperty
  a_valid: assert property (p_valid) else $error("valid too early");
  property p_tgrade;
    time_accuracy_grade >= 4'h3 && time_accuracy_grade <= 4'h9;
  endproperty
  a_tgrade: assert property (p_tgrade) else $error("grade range");
  property p_fhold;
    !$past(reset) && mode == `GHMT_MODE_HOLD
      |-> frequency_stability_grade == `GHMT_FGRADE_HOLD;
  endproperty
  a_fhold: assert property (p_fhold) else $error("hold fgrade");
  property p_manual;
    mode == `GHMT_MODE_HOLD && hold_cause == `GHMT_CAUSE_MANUAL
      && !hold_exit && !$past(hold_exit) |=> mode == `GHMT_MODE_HOLD;
  endproperty
  a_manual: assert property (p_manual) else $error("left manual");
  property p_entry;
    $rose(mode[3]) && !$past(mode[2])
      |-> hold_cause != `GHMT_CAUSE_NONE && hold_seconds == 0;
  endproperty
  a_entry: assert property (p_entry) else $error("hold entry");
  property p_settle;
    freq_settling |-> mode == `GHMT_MODE_LOCKED && pps_usable;
  endproperty
  a_settle: assert property (p_settle) else $error("settling flag");
  c_manual: cover property (hold_cause == `GHMT_CAUSE_MANUAL && mode[3]);
  c_thresh: cover property (hold_cause == `GHMT_CAUSE_THRESH && mode[3]);
  c_valid: cover property (output_summary == `GHMT_SUM_VALID);
  c_recov: cover property (mode == `GHMT_MODE_RECOV);
endmodule

//--- bench/ghmt_host_model.sv
// host side: issues holdover commands and sets the limit
// assumes commands launched on core_clk rising edges
`timescale 1ns/1ps
module ghmt_host_model (
  // clock
  input  wire        core_clk,
  // commands
  output reg         hold_request,
  output reg         hold_exit,
  output reg  [31:0] holdover_limit
);
  initial
  begin
    hold_request = 1'b0;
    hold_exit = 1'b0;
    holdover_limit = 32'h0000_ffff;
  end
  task automatic request_hold();
    @(posedge core_clk);
    hold_request <= 1'b1;
    @(posedge core_clk);
    hold_request <= 1'b0;
  endtask
  // manual holdover is left only through this command
  task automatic request_exit();
    @(posedge core_clk);
    hold_exit <= 1'b1;
    @(posedge core_clk);
    hold_exit <= 1'b0;
  endtask
  task automatic set_limit(input logic [31:0] v);
    @(posedge core_clk);
    holdover_limit <= v;
  endtask
endmodule

//--- bench/testbench.sv
// directed test of the holdover mode tracker
// assumes host model drives commands; bench drives engine and loop
`timescale 1ns/1ps
`include "ghmt_consts.vh"
module testbench;
  reg         core_clk, reset, ref_pps_valid, sats_tracked, ref_pps_in;
  reg         own_pps_in, loop_locked, loop_stable, osc_freq_ok;
  reg         meas_hw_error;
  reg  [3:0]  time_error_decade;
  wire        hold_request, hold_exit, offset_negative, lock_led;
  wire        pps_usable, freq_settling, osc_steer_en;
  wire [31:0] holdover_limit, hold_seconds, pulse_phase_offset;
  wire [3:0]  mode, time_accuracy_grade;
  wire [2:0]  hold_cause;
  wire [1:0]  output_summary, frequency_stability_grade;
  int         miscompares, num_checks, i;
  logic [3:0] d, e;
  ghmt_tracker u_ghmt_tracker (.core_clk(core_clk), .reset(reset),
    .ref_pps_valid(ref_pps_valid), .sats_tracked(sats_tracked),
    .ref_pps_in(ref_pps_in), .own_pps_in(own_pps_in),
    .loop_locked(loop_locked), .loop_stable(loop_stable),
    .osc_freq_ok(osc_freq_ok), .meas_hw_error(meas_hw_error),
    .time_error_decade(time_error_decade), .hold_request(hold_request),
    .hold_exit(hold_exit), .holdover_limit(holdover_limit), .mode(mode),
    .hold_cause(hold_cause), .output_summary(output_summary),
    .time_accuracy_grade(time_accuracy_grade),
    .frequency_stability_grade(frequency_stability_grade),
    .hold_seconds(hold_seconds), .pulse_phase_offset(pulse_phase_offset),
    .offset_negative(offset_negative), .lock_led(lock_led),
    .pps_usable(pps_usable), .freq_settling(freq_settling),
    .osc_steer_en(osc_steer_en));
  ghmt_host_model u_ghmt_host_model (.core_clk(core_clk),
    .hold_request(hold_request), .hold_exit(hold_exit),
    .holdover_limit(holdover_limit));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic settle();
    repeat (4) @(posedge core_clk);
    #1;
  endtask
  task automatic wait_mode(input logic [3:0] m);
    int n;
    n = 0;
    #1;
    while (mode !== m && n < 40)
    begin
      @(posedge core_clk);
      #1;
      n++;
    end
    chk(mode, m);
  endtask
  task automatic pulses(input logic own_first, input int gap);
    @(posedge core_clk);
    if (own_first) own_pps_in <= 1'b1;
    else ref_pps_in <= 1'b1;
    repeat (gap) @(posedge core_clk);
    if (own_first) ref_pps_in <= 1'b1;
    else own_pps_in <= 1'b1;
    repeat (4) @(posedge core_clk);
    own_pps_in <= 1'b0;
    ref_pps_in <= 1'b0;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, miscompares);
    if (miscompares == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    core_clk = 1'b0;
    forever #2.5 core_clk = ~core_clk;
  end
  initial
  begin
    #200000;
    miscompares++;
    final_report();
  end
  initial
  begin
    {ref_pps_valid, sats_tracked, ref_pps_in, own_pps_in} = 4'h0;
    {loop_locked, loop_stable, osc_freq_ok, meas_hw_error} = 4'h0;
    time_error_decade = 4'h0;
    miscompares = 0;
    num_checks = 0;
    reset = 1'b1;
    repeat (5) @(posedge core_clk);
    reset <= 1'b0;
    settle();
    chk({mode, hold_cause}, {4'h1, 3'h0});
    chk(hold_seconds, 32'h0);
    chk({output_summary, time_accuracy_grade}, {2'h0, 4'h9});
    chk({osc_steer_en, frequency_stability_grade}, {1'b1, 2'h3});
    u_ghmt_host_model.request_hold();
    settle();
    chk(mode, `GHMT_MODE_PWRUP);
    @(posedge core_clk);
    ref_pps_valid <= 1'b1;
    sats_tracked <= 1'b1;
    osc_freq_ok <= 1'b1;
    settle();
    chk({mode, lock_led, pps_usable, freq_settling}, {4'h2, 3'h7});
    chk({output_summary, frequency_stability_grade}, 4'h5);
    for (i = 0; i < 16; i += 3)
    begin
      d = i[3:0];
      e = (d < 4'h3) ? 4'h3 : ((d > 4'h9) ? 4'h9 : d);
      @(posedge core_clk);
      time_error_decade <= d;
      settle();
      chk(time_accuracy_grade, e);
    end
    @(posedge core_clk);
    loop_stable <= 1'b1;
    settle();
    chk({output_summary, frequency_stability_grade, freq_settling},
      {2'h2, 2'h0, 1'b0});
    u_ghmt_host_model.request_hold();
    settle();
    chk({mode, hold_cause}, {4'h8, 3'h2});
    chk(hold_seconds, 32'h0);
    chk({output_summary, frequency_stability_grade}, 4'h6);
    repeat (20) @(posedge core_clk);
    #1;
    chk(mode, `GHMT_MODE_HOLD);
    u_ghmt_host_model.request_exit();
    settle();
    chk({mode, frequency_stability_grade}, {4'h4, 2'h1});
    @(posedge core_clk);
    loop_locked <= 1'b1;
    wait_mode(`GHMT_MODE_LOCKED);
    chk(hold_cause, `GHMT_CAUSE_NONE);
    @(posedge core_clk);
    meas_hw_error <= 1'b1;
    wait_mode(`GHMT_MODE_HOLD);
    chk(hold_cause, `GHMT_CAUSE_HWFAULT);
    @(posedge core_clk);
    meas_hw_error <= 1'b0;
    wait_mode(`GHMT_MODE_LOCKED);
    @(posedge core_clk);
    ref_pps_valid <= 1'b0;
    wait_mode(`GHMT_MODE_HOLD);
    chk(hold_cause, `GHMT_CAUSE_REFINV);
    @(posedge core_clk);
    ref_pps_valid <= 1'b1;
    wait_mode(`GHMT_MODE_LOCKED);
    pulses(1'b0, 7);
    settle();
    chk(offset_negative, 1'b0);
    chk(pulse_phase_offset, 32'h7);
    u_ghmt_host_model.set_limit(32'ha);
    pulses(1'b1, 20);
    wait_mode(`GHMT_MODE_HOLD);
    chk(offset_negative, 1'b1);
    chk(pulse_phase_offset, 32'h14);
    chk(hold_cause, `GHMT_CAUSE_THRESH);
    u_ghmt_host_model.set_limit(32'h0000_ffff);
    wait_mode(`GHMT_MODE_LOCKED);
    @(posedge core_clk);
    reset <= 1'b1;
    repeat (2) @(posedge core_clk);
    #1;
    chk({mode, hold_cause, output_summary, time_accuracy_grade},
      {4'h1, 3'h0, 2'h0, 4'h9});
    @(posedge core_clk);
    reset <= 1'b0;
    wait_mode(`GHMT_MODE_LOCKED);
    final_report();
  end
endmodule
bind ghmt_tracker ghmt_assertions u_ghmt_assertions (.core_clk(core_clk),
  .reset(reset), .mode(mode), .hold_cause(hold_cause),
  .output_summary(output_summary), .hold_exit(hold_exit),
  .time_accuracy_grade(time_accuracy_grade),
  .frequency_stability_grade(frequency_stability_grade),
  .hold_seconds(hold_seconds), .lock_led(lock_led),
  .pps_usable(pps_usable), .freq_settling(freq_settling),
  .osc_steer_en(osc_steer_en));
